// File: src/cpu_port_device.sv
`timescale 1ns/10ps
module cpu_port_device
	import cpu_port_pkg::*;
(
	input  wire logic              clk,         // 100 MHz clock
	input  wire logic              rst_b,       // Sync reset, active low
	cpu_port_if.device             bus,         // Host-facing pins
	input  wire logic              phy_reference_clock, // Ref clock pin
	input  wire logic              ref_rate_select,     // 1: 8 kHz
	output logic                   req_valid,   // Access started
	output logic                   req_write,   // Access is a write
	output logic                   req_mem,     // Access targets memory
	output logic [ADDR_W-1:0]      req_addr,    // Word address
	output logic [DATA_W-1:0]      req_wdata,   // Write data
	input  wire logic              mem_done,    // Memory finished
	input  wire logic [DATA_W-1:0] user_rdata,  // Read data to return
	output logic                   ref_tick,    // Reference rising edge
	output logic                   ref_rate_q   // Rate in use
);
	typedef struct packed {
		dev_state_e        st;
		logic [CNT_W-1:0]  cnt;
		logic [4:0]        cs_s, rd_s, wr_s, ds_s, rw_s;
		logic [1:0]        ref_s;
		logic              ref_last;
		logic              rate;
		logic              tick;
		logic              write, mem, valid, mdone;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wd, rd;
		logic              rd_oe, rdy, rdy_oe;
	} dev_s;
	dev_s q, d;
	logic cs_a, rd_a, wr_a, ds_a, rw_a, start_rd, start_wr, act;
	logic [CNT_W-1:0] lat;
	// Strobe levels after the second synchroniser stage only
	assign cs_a  = !q.cs_s[1];
	assign rd_a  = !q.rd_s[1];
	assign wr_a  = !q.wr_s[1];
	assign ds_a  = !q.ds_s[1];
	assign rw_a  = q.rw_s[1];
	assign start_rd = bus.strobe_pair_mode ? (cs_a && rd_a)
	                                       : (cs_a && ds_a && rw_a);
	assign start_wr = bus.strobe_pair_mode ? (cs_a && wr_a)
	                                       : (cs_a && ds_a && !rw_a);
	// Access stays live only while select and its strobe hold
	assign act = q.write ? start_wr : start_rd;
	// Read or write latency by direction, shared by both bus styles; memory stretches it
	assign lat = q.write ? (q.mem ? WR_MEM_LAT : WR_REG_LAT)
	                     : (q.mem ? RD_MEM_LAT : RD_REG_LAT);
	// Next state
	always_comb begin
		d = q;
		d.cs_s  = {3'h0, q.cs_s[0], bus.cs_n};
		d.rd_s  = {3'h0, q.rd_s[0], bus.rd_n};
		d.wr_s  = {3'h0, q.wr_s[0], bus.wr_n};
		d.ds_s  = {3'h0, q.ds_s[0], bus.data_strobe_n};
		d.rw_s  = {3'h0, q.rw_s[0], bus.rw};
		d.ref_s = {q.ref_s[0], phy_reference_clock};
		d.ref_last = q.ref_s[1];
		d.tick  = q.ref_s[1] && !q.ref_last;
		d.rate  = ref_rate_select;
		d.valid = 1'b0;
		d.mdone = q.mdone || mem_done;
		// Drive ready low / ack high as soon as select is seen
		d.rdy_oe = cs_a;
		unique case (q.st)
			DEV_IDLE: begin
				d.rdy   = 1'b0;
				d.rd_oe = 1'b0;
				if (start_rd || start_wr) begin
					d.st    = DEV_WAIT;
					d.cnt   = '0;
					d.write = start_wr;
					d.mem   = bus.memory_space_qualifier;
					d.addr  = bus.addr;
					d.wd    = bus.data_bus;
					d.valid = 1'b1;
					d.mdone = 1'b0;
				end
			end
			DEV_WAIT: begin
				d.cnt = q.cnt + 8'h01;
				if (!act) begin
					d.st = DEV_IDLE;
				end else if (q.cnt + 8'h01 == lat - 8'h01 && !q.write
				             && (!q.mem || q.mdone ||
				                 q.cnt >= MEM_MAX_LAT - 8'h02)) begin
					d.rd    = user_rdata;
					d.rd_oe = 1'b1;
				end else if (q.cnt >= lat - 8'h01 &&
				             (!q.mem || q.mdone || q.write ||
				              q.cnt >= MEM_MAX_LAT - 8'h01) &&
				             (q.write || q.rd_oe)) begin
					d.rdy = 1'b1;
					d.st  = DEV_DONE;
				end else if (q.mem && !q.write && q.cnt + 8'h01 >= lat
				             && (q.mdone || q.cnt >= MEM_MAX_LAT - 8'h02))
				begin
					d.rd    = user_rdata;
					d.rd_oe = 1'b1;
				end
			end
			DEV_DONE: begin
				if (!act) begin
					d.st    = DEV_IDLE;
					d.rdy   = 1'b0;
					d.rd_oe = 1'b0;
				end
			end
			default: d.st = DEV_IDLE;
		endcase
		if (!cs_a) begin
			d.rd_oe = 1'b0;
		end
	end
	// Single register stage for all state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
			q.cs_s <= 5'h1f;
			q.rd_s <= 5'h1f;
			q.wr_s <= 5'h1f;
			q.ds_s <= 5'h1f;
			q.rate <= REF_RATE_RST;
		end else begin
			q <= d;
		end
	end
	// Ready level: pair mode high means ready; ack is active low
	assign bus.rdy_o    = bus.strobe_pair_mode ? q.rdy : !q.rdy;
	assign bus.rdy_oe   = q.rdy_oe;
	assign bus.rdata    = q.rd;
	assign bus.rdata_oe = q.rd_oe;
	assign req_valid    = q.valid;
	assign req_write    = q.write;
	assign req_mem      = q.mem;
	assign req_addr     = q.addr;
	assign req_wdata    = q.wd;
	assign ref_tick     = q.tick;
	assign ref_rate_q   = q.rate;
endmodule : cpu_port_device

// File: src/cpu_port_host.sv
`timescale 1ns/10ps
module cpu_port_host
	import cpu_port_pkg::*;
(
	input  wire logic              clk,       // 100 MHz clock
	input  wire logic              rst_b,     // Sync reset, active low
	cpu_port_if.host               bus,       // Device-facing pins
	input  wire logic              pair_mode, // Bus style strap
	input  wire logic              cmd_valid, // Start an access
	input  wire logic              cmd_write, // 1 write, 0 read
	input  wire logic              cmd_mem,   // Memory space
	input  wire logic [ADDR_W-1:0] cmd_addr,  // Word address
	input  wire logic [DATA_W-1:0] cmd_wdata, // Write data
	output logic                   cmd_ready, // Idle, may accept
	output logic                   done,      // Access finished pulse
	output logic                   timeout,   // No answer pulse
	output logic [DATA_W-1:0]      rdata      // Captured read data
);
	typedef struct packed {
		host_state_e       st;
		logic [CNT_W-1:0]  cnt;
		logic [1:0]        rdy_s;
		logic              cs_n, rd_n, wr_n, ds_n, rw, mem, oe, mode;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wd, rd;
		logic              done, tmo, crdy;
		logic              armed;
	} host_s;
	host_s q, d;
	logic seen;
	// Answer after sync: ready high in pair mode, ack low otherwise
	assign seen = q.mode ? q.rdy_s[1] : !q.rdy_s[1];
	// Next state
	always_comb begin
		d = q;
		d.rdy_s = {q.rdy_s[0], bus.ready_line};
		d.done = 1'b0;
		d.tmo  = 1'b0;
		unique case (q.st)
			HST_IDLE: begin
				d.crdy = 1'b1;
				if (cmd_valid) begin
					// Address, qualifier, direction settle first
					d.addr = cmd_addr;
					d.mem  = cmd_mem;
					d.rw   = !cmd_write;
					d.wd   = cmd_wdata;
					d.oe   = cmd_write;
					d.mode = pair_mode;
					d.crdy = 1'b0;
					d.st   = HST_SETUP;
				end
			end
			HST_SETUP: begin
				d.cs_n = 1'b0;
				d.rd_n = !(q.mode && q.rw);
				d.wr_n = !(q.mode && !q.rw);
				d.ds_n = q.mode;
				d.cnt  = '0;
				d.armed = 1'b0;
				d.st   = HST_WAIT;
			end
			HST_WAIT: begin
				d.cnt = q.cnt + 8'h01;
				// The pulled-up idle line reads as ready in pair mode, so
				// an answer counts only after the not-ready level was seen
				if (!seen) begin
					d.armed = 1'b1;
				end
				// Hold strobes until the answer arrives
				if (seen && q.armed) begin
					d.rd = bus.data_bus;
					d.st = HST_END;
				end else if (q.cnt == HOST_TIMEOUT) begin
					d.tmo = 1'b1;
					d.st  = HST_END;
				end
			end
			HST_END: begin
				d.cs_n = 1'b1;
				d.rd_n = 1'b1;
				d.wr_n = 1'b1;
				d.ds_n = 1'b1;
				d.oe   = 1'b0;
				d.done = 1'b1;
				d.cnt  = '0;
				d.st   = HST_GAP;
			end
			HST_GAP: begin
				// Extra margin covers the device's input synchroniser
				d.cnt = q.cnt + 8'h01;
				if (q.cnt == GAP_CYCLES + 8'h02) begin
					d.st = HST_IDLE;
					d.crdy = 1'b1;
				end
			end
			default: d.st = HST_IDLE;
		endcase
	end
	// Single register stage for all state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
			q.cs_n <= 1'b1;
			q.rd_n <= 1'b1;
			q.wr_n <= 1'b1;
			q.ds_n <= 1'b1;
			q.rw   <= 1'b1;
			q.mode <= 1'b1;
			q.rdy_s <= 2'h3;
		end else begin
			q <= d;
		end
	end
	assign bus.strobe_pair_mode       = q.mode;
	assign bus.cs_n                   = q.cs_n;
	assign bus.rd_n                   = q.rd_n;
	assign bus.wr_n                   = q.wr_n;
	assign bus.data_strobe_n          = q.ds_n;
	assign bus.rw                     = q.rw;
	assign bus.memory_space_qualifier = q.mem;
	assign bus.addr                   = q.addr;
	assign bus.wdata                  = q.wd;
	assign bus.wdata_oe               = q.oe;
	assign cmd_ready = q.crdy;
	assign done      = q.done;
	assign timeout   = q.tmo;
	assign rdata     = q.rd;
endmodule : cpu_port_host

// File: src/cpu_port_if.sv
`timescale 1ns/10ps
// Shared pins; resolution of the ready/ack wire and data bus is here.
interface cpu_port_if;
	import cpu_port_pkg::*;
	logic              strobe_pair_mode; // 1: read/write strobes
	logic              cs_n;             // Chip select
	logic              rd_n;             // Read strobe (pair mode)
	logic              wr_n;             // Write strobe (pair mode)
	logic              data_strobe_n;    // Data strobe (direction mode)
	logic              rw;               // 1 read, 0 write (direction mode)
	logic              memory_space_qualifier; // 1 memory, 0 registers
	logic [ADDR_W-1:0] addr;             // Word address bits 20:1
	logic [DATA_W-1:0] wdata;            // Host write data
	logic              wdata_oe;         // Host drives data bus
	logic [DATA_W-1:0] rdata;            // Device read data
	logic              rdata_oe;         // Device drives data bus
	logic              rdy_o;            // Ready / transfer_ack_n level
	logic              rdy_oe;           // Device drives ready line
	wire  [DATA_W-1:0] data_bus = wdata_oe ? wdata :
	                              rdata_oe ? rdata : '1;
	wire               ready_line = rdy_oe ? rdy_o : 1'b1; // Pull-up
	modport device (input strobe_pair_mode, cs_n, rd_n, wr_n,
		data_strobe_n, rw, memory_space_qualifier, addr, data_bus,
		output rdata, rdata_oe, rdy_o, rdy_oe);
	modport host (input ready_line, data_bus,
		output strobe_pair_mode, cs_n, rd_n, wr_n, data_strobe_n, rw,
		memory_space_qualifier, addr, wdata, wdata_oe);
endinterface : cpu_port_if

// File: src/cpu_port_pkg.sv
// Functional notes
// - Read needs select and read strobe together
// - Read ends when select or strobe drops
// - Write needs select plus write or data strobe
// - Write ends when select or strobe drops
// - Select idle three clocks between accesses
// - Ready driven low soon after select
// - Acknowledge driven high soon after select
// - Ready or acknowledge released when deselected
// - Read ready 13-16 register, 14-133 memory
// - Pair write ready 11-14 register, 12-133 memory
// - Direction write ack 11-14 register, 12-133 memory
// - Read data valid one clock before ready
// - Host holds write until ready seen
// - Address and qualifier stable through strobes
// - Direction, qualifier, address set before strobes
// - Reference clock 19.44 MHz or 8 kHz by select
package cpu_port_pkg;
	localparam int ADDR_W        = 20;
	localparam int DATA_W        = 16;
	localparam int CNT_W         = 8;
	// Latencies in clock cycles, counted from the cycle the strobe is seen
	localparam logic [7:0] RD_REG_LAT  = 8'h0e; // 14, inside 13..16
	localparam logic [7:0] RD_MEM_LAT  = 8'h0f; // 15, memory minimum
	localparam logic [7:0] WR_REG_LAT  = 8'h0c; // 12, inside 11..14
	localparam logic [7:0] WR_MEM_LAT  = 8'h0d; // 13, memory minimum
	localparam logic [7:0] MEM_MAX_LAT = 8'h84; // 132, below 133
	localparam logic [7:0] GAP_CYCLES  = 8'h03;
	localparam logic [7:0] HOST_TIMEOUT = 8'hc8;
	localparam logic [0:0] REF_RATE_RST = 1'h0; // 0: 19.44 MHz, 1: 8 kHz
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_WAIT = 2'b01,
		DEV_DONE = 2'b10
	} dev_state_e;
	typedef enum logic [2:0] {
		HST_IDLE  = 3'b000,
		HST_SETUP = 3'b001,
		HST_WAIT  = 3'b010,
		HST_END   = 3'b011,
		HST_GAP   = 3'b100
	} host_state_e;
endpackage : cpu_port_pkg

// File: verification/cpu_port_chk.sv
`timescale 1ns/10ps
module cpu_port_chk (
	input wire logic clk,              // Clock
	input wire logic rst_b,            // Sync reset
	input wire logic strobe_pair_mode, // Bus style
	input wire logic cs_n,             // Select
	input wire logic rd_n,             // Read strobe
	input wire logic wr_n,             // Write strobe
	input wire logic data_strobe_n,    // Data strobe
	input wire logic rw,               // Direction
	input wire logic memory_space_qualifier, // Memory space
	input wire logic rdata_oe,         // Device drives data
	input wire logic rdy_o,            // Ready level
	input wire logic rdy_oe            // Ready driven
);
	// Pin figures plus up to three cycles of input synchronising
	localparam int RR_MIN = 13;
	localparam int RR_MAX = 19;
	localparam int RM_MIN = 14;
	localparam int M_MAX  = 136;
	localparam int WR_MIN = 11;
	localparam int WR_MAX = 17;
	localparam int WM_MIN = 12;
	logic       rd_acc;
	logic       strobe;
	logic       rdy_act;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	assign rd_acc  = strobe_pair_mode ? !rd_n : rw;
	assign strobe  = strobe_pair_mode ? (!rd_n || !wr_n) : !data_strobe_n;
	assign rdy_act = rdy_oe && (strobe_pair_mode ? rdy_o : !rdy_o);
	// Cycles with select and strobe both low; saturates, never wraps
	always_comb begin
		cnt_d = 8'h00;
		if (!cs_n && strobe)
			cnt_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
	end
	always_ff @(posedge clk) begin
		cnt_q <= rst_b ? cnt_d : 8'h00;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_ready_low_select: assert property (strobe_pair_mode && $fell(cs_n) |-> ##[0:4] (rdy_oe && !rdy_o)) else $error("ready not driven low");
	a_ack_high_select: assert property (!strobe_pair_mode && $fell(cs_n) |-> ##[0:4] (rdy_oe && rdy_o)) else $error("ack not driven high");
	a_release_deselect: assert property ($rose(cs_n) |-> ##[1:4] !rdy_oe) else $error("ready line not released");
	a_read_reg_lat: assert property ($rose(rdy_act) && rd_acc && !memory_space_qualifier |-> cnt_q inside {[RR_MIN:RR_MAX]}) else $error("register read latency");
	a_read_mem_lat: assert property ($rose(rdy_act) && rd_acc && memory_space_qualifier |-> cnt_q inside {[RM_MIN:M_MAX]}) else $error("memory read latency");
	a_write_reg_lat: assert property ($rose(rdy_act) && !rd_acc && !memory_space_qualifier |-> cnt_q inside {[WR_MIN:WR_MAX]}) else $error("register write latency");
	a_write_mem_lat: assert property ($rose(rdy_act) && !rd_acc && memory_space_qualifier |-> cnt_q inside {[WM_MIN:M_MAX]}) else $error("memory write latency");
	a_data_before_ready: assert property ($rose(rdy_act) && rd_acc |-> $past(rdata_oe) && rdata_oe) else $error("read data late");
	c_pair_read: cover property ($rose(rdy_act) && strobe_pair_mode && rd_acc);
	c_dir_write: cover property ($rose(rdy_act) && !strobe_pair_mode && !rd_acc);
	c_mem_access: cover property ($rose(rdy_act) && memory_space_qualifier);
endmodule : cpu_port_chk

// File: verification/host_cpu_port_handshake_test.sv
`timescale 1ns/10ps
module host_cpu_port_handshake_test
	import cpu_port_pkg::*;
;
	logic clk, rst_b, pair_mode, cmd_valid, cmd_write, cmd_mem, cmd_ready;
	logic done, timeout, mem_done, phy_reference_clock, ref_rate_select;
	logic req_valid, req_write, req_mem, ref_tick, ref_rate_q;
	logic [ADDR_W-1:0] cmd_addr, req_addr;
	logic [DATA_W-1:0] cmd_wdata, rdata, user_rdata, req_wdata;
	logic [7:0] mem_wait, mem_cnt;
	int fail_count, num_checks, cycles, ticks;
	cpu_port_if cpu_port_if_i ();
	cpu_port_device cpu_port_device_i (.clk, .rst_b, .bus(cpu_port_if_i),
		.phy_reference_clock, .ref_rate_select, .req_valid, .req_write,
		.req_mem, .req_addr, .req_wdata, .mem_done, .user_rdata, .ref_tick,
		.ref_rate_q);
	cpu_port_host cpu_port_host_i (.clk, .rst_b, .bus(cpu_port_if_i),
		.pair_mode, .cmd_valid, .cmd_write, .cmd_mem, .cmd_addr, .cmd_wdata,
		.cmd_ready, .done, .timeout, .rdata);
	cpu_port_chk cpu_port_chk_i (.clk, .rst_b,
		.strobe_pair_mode(cpu_port_if_i.strobe_pair_mode),
		.cs_n(cpu_port_if_i.cs_n), .rd_n(cpu_port_if_i.rd_n),
		.wr_n(cpu_port_if_i.wr_n), .rw(cpu_port_if_i.rw),
		.data_strobe_n(cpu_port_if_i.data_strobe_n),
		.memory_space_qualifier(cpu_port_if_i.memory_space_qualifier),
		.rdata_oe(cpu_port_if_i.rdata_oe), .rdy_o(cpu_port_if_i.rdy_o),
		.rdy_oe(cpu_port_if_i.rdy_oe));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Reference clock near 19.44 MHz, unrelated to clk
	initial begin
		phy_reference_clock = 1'b0;
		forever #25.72 phy_reference_clock = ~phy_reference_clock;
	end
	// Memory side answers mem_wait cycles after the request; 0 never answers
	always @(posedge clk) begin
		cycles++;
		if (ref_tick === 1'b1)
			ticks++;
		mem_cnt <= req_valid ? mem_wait : (mem_cnt != 8'h00 ? mem_cnt - 8'h01 : mem_cnt);
		mem_done <= (mem_cnt == 8'h01);
		if (cycles >= 20000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic check_word(input logic [ADDR_W-1:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check_word
	task automatic check_bit(input logic got, exp);
		check_word({19'h00000, got}, {19'h00000, exp});
	endtask : check_bit
	// One host access; read data is the inverse of the write pattern
	task automatic access(input logic pm, w, m, input logic [19:0] a, input logic [15:0] d);
		int n;
		logic to_seen;
		n = 0;
		to_seen = 1'b0;
		while (cmd_ready !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		pair_mode <= pm;
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_mem <= m;
		cmd_addr <= a;
		cmd_wdata <= d;
		user_rdata <= ~d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			// Timeout pulses a cycle before done, so remember it
			if (timeout !== 1'b0)
				to_seen = 1'b1;
		end while (done !== 1'b1 && n < 400);
		check_bit(done, 1'b1);
		check_bit(to_seen, 1'b0);
		check_bit(req_write, w);
		check_bit(req_mem, m);
		check_word(req_addr, a);
		if (w)
			check_word({4'h0, req_wdata}, {4'h0, d});
		else
			check_word({4'h0, rdata}, {4'h0, ~d});
	endtask : access
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	initial begin
		rst_b = 1'b0;
		pair_mode = 1'b1;
		{cmd_valid, cmd_write, cmd_mem, ref_rate_select} = 4'h0;
		cmd_addr = 20'h00000;
		cmd_wdata = 16'h0000;
		user_rdata = 16'h0000;
		mem_wait = 8'h14;
		// Known memory model state, or a stale unknown sticks in the latch
		mem_cnt = 8'h00;
		mem_done = 1'b0;
		{fail_count, num_checks, cycles, ticks} = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		// Both bus styles, reads and writes, both spaces, back to back
		for (int i = 0; i < 8; i++) begin
			mem_wait <= i[2] ? 8'h14 : 8'h01;
			access(i[2], i[0], i[1], 20'ha5c30 ^ 20'(i), 16'h5a0f ^ 16'(i));
		end
		// Memory never answers: a read's ready is forced before the host gives up; the write does not wait for memory
		mem_wait <= 8'h00;
		access(1'b1, 1'b0, 1'b1, 20'hfffff, 16'h8001);
		access(1'b0, 1'b1, 1'b1, 20'h00001, 16'h7ffe);
		ticks = 0;
		repeat (1000) @(negedge clk);
		check_bit(ticks inside {[192:197]}, 1'b1);
		for (int r = 1; r >= 0; r--) begin
			@(posedge clk);
			ref_rate_select <= r[0];
			repeat (4) @(negedge clk);
			check_bit(ref_rate_q, r[0]);
		end
		complete_run();
	end
endmodule : host_cpu_port_handshake_test
